// File: common/tosq_regs.vh
// What this block does
// (R01) ten balanced plus ten single-ended square outputs
// (R02) each port can be switched off alone
// (R03) per-port frequency 8-4096 kHz in 8 kHz steps
// (R04) port n+10 follows frequency of port n
// (R05) redundant partner change: blank, retune, lock, re-enable
// (R06) threshold zero never squelches the port
// (R07) squelch when system level exceeds nonzero threshold
// (R08) squelch works on all twenty ports
// (R09) squelch change raises alarm 14 with ports
// (R10) twenty-bit mask, first digit ports 1-4
// (R11) digit msb is lowest-numbered port
// (R12) unsquelched ports keep running; squelched ports resume
`ifndef TOSQ_REGS_VH
`define TOSQ_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TOSQ_OFS_CTRL 8'h00
`define TOSQ_OFS_PORT_OFF 8'h04
`define TOSQ_OFS_SYS_PQL 8'h08
`define TOSQ_OFS_SQ_STATE 8'h0C
`define TOSQ_OFS_ALARM 8'h10
`define TOSQ_OFS_STATUS 8'h14
`define TOSQ_OFS_FREQ_BASE 8'h40
`define TOSQ_OFS_THR_BASE 8'h80

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TOSQ_CTRL_REDUNDANT 0
`define TOSQ_ALARM_EVENT 20
`define TOSQ_ALARM_ID_LSB 24
`define TOSQ_STATUS_BLANK 0
`define TOSQ_STATUS_WAIT 1

// ----------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------
`define TOSQ_CTRL_RST 1'b0
`define TOSQ_PORT_OFF_RST 20'h0_0000
`define TOSQ_PQL_RST 4'h0
`define TOSQ_FREQ_RST 10'h100
`define TOSQ_FREQ_MIN 10'h001
`define TOSQ_FREQ_MAX 10'h200
`define TOSQ_THR_RST 4'h0
`define TOSQ_ALARM_ID 6'h0E

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TOSQ_CLK_KHZ 125000
`define TOSQ_STEP_KHZ 8
`define TOSQ_CLK_NS 8
`define TOSQ_SETTLE_NS 1000
`define TOSQ_SETTLE_CYC ((`TOSQ_SETTLE_NS + `TOSQ_CLK_NS - 1) / `TOSQ_CLK_NS)
`define TOSQ_ALIGN_TIMEOUT_US 1000
`define TOSQ_ALIGN_TIMEOUT_CYC (`TOSQ_ALIGN_TIMEOUT_US * 1000 / `TOSQ_CLK_NS)

`endif

// File: src/tosq_divider.v
`timescale 1ns/1ps
`default_nettype none
`include "tosq_regs.vh"

// exact-average square wave: the accumulator adds twice the output
// frequency per clock and toggles on each wrap of the clock rate
module tosq_divider #(
	parameter ACC_W = 17
) (
	input wire hclk,
	input wire hresetn,
	input wire [9:0] code,
	input wire align,
	output reg wave
);
	localparam integer MODULUS_INT = `TOSQ_CLK_KHZ;
	localparam [ACC_W:0] MODULUS = MODULUS_INT[ACC_W:0];
	reg [ACC_W-1:0] acc;
	wire [ACC_W:0] sum;

	// two toggles per period, so step is 2 x 8 kHz per code unit
	assign sum = {1'b0, acc} + {{(ACC_W-13){1'b0}}, code, 4'h0}; // R03

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc <= {ACC_W{1'b0}};
			wave <= 1'b0;
		end else if (align) begin
			acc <= {ACC_W{1'b0}}; // R05
			wave <= 1'b0;
		end else if (sum >= MODULUS) begin
			acc <= sum[ACC_W-1:0] - MODULUS[ACC_W-1:0];
			wave <= ~wave;
		end else begin
			acc <= sum[ACC_W-1:0];
		end
	end
endmodule // tosq_divider

`default_nettype wire

// File: src/tosq_squelch.v
`timescale 1ns/1ps
`default_nettype none

module tosq_squelch #(
	parameter PORTS = 20,
	parameter QW = 4
) (
	input wire [QW-1:0] pql,
	input wire [PORTS*QW-1:0] thr_flat,
	output wire [PORTS-1:0] squelch,
	output wire [PORTS-1:0] report
);
	genvar i;
	generate
		for (i = 0; i < PORTS; i = i + 1) begin : g_port
			wire [QW-1:0] thr = thr_flat[i*QW +: QW];
			// zero threshold leaves the port running at any level
			assign squelch[i] = (thr != {QW{1'b0}}) && (pql > thr); // R06 R07 R08
			// port 1 lands in the top bit: msb of the first digit
			assign report[PORTS-1-i] = squelch[i]; // R10 R11
		end
	endgenerate
endmodule // tosq_squelch

`default_nettype wire

// File: src/tosq_top.v
`timescale 1ns/1ps
`default_nettype none
`include "tosq_regs.vh"

module tosq_top #(
	parameter PAIRS = 10,
	parameter QW = 4,
	parameter ALIGN_TIMEOUT = `TOSQ_ALIGN_TIMEOUT_CYC
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg [31:0] hrdata,
	output reg hresp,
	input wire partner_freq_load,
	input wire [3:0] partner_freq_index,
	input wire [9:0] partner_freq_code,
	input wire partner_align,
	output reg notify_freq_load,
	output reg [3:0] notify_freq_index,
	output reg [9:0] notify_freq_code,
	output reg [PAIRS-1:0] balanced_tip_out,
	output reg [PAIRS-1:0] balanced_ring_out,
	output reg [PAIRS-1:0] single_out,
	output reg [2*PAIRS-1:0] port_relay_closed,
	output reg squelch_alarm,
	output reg [2*PAIRS-1:0] squelch_port_mask
);
	localparam PORTS = 2 * PAIRS;
	localparam [1:0] RL_RUN = 2'd0;
	localparam [1:0] RL_WAIT = 2'd1;
	localparam [1:0] RL_SETTLE = 2'd2;
	localparam integer SETTLE_INT = `TOSQ_SETTLE_CYC;
	localparam [7:0] SETTLE_CYC = SETTLE_INT[7:0];
	localparam [31:0] TIMEOUT_CYC = ALIGN_TIMEOUT;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	reg redundant_en;
	reg [PORTS-1:0] port_off;
	reg [QW-1:0] sys_pql;
	reg [PAIRS*10-1:0] freq_flat;
	reg [PORTS*QW-1:0] thr_flat;
	reg alarm_event;
	reg [PORTS-1:0] alarm_mask;
	reg [PORTS-1:0] squelch_q;

	// ----------------------------------------------------------------
	// bus pipeline state
	// ----------------------------------------------------------------
	reg wr_pend;
	reg rd_pend;
	reg [7:0] dp_addr;

	// ----------------------------------------------------------------
	// relock state
	// ----------------------------------------------------------------
	reg [1:0] rl_state;
	reg [7:0] settle_cnt;
	reg [31:0] wait_cnt;
	reg align_pulse;

	wire [PAIRS-1:0] wave;
	wire [PORTS-1:0] squelch;
	wire [PORTS-1:0] report;
	wire blank;
	wire accept;
	wire [PORTS-1:0] live;
	wire [9:0] wr_code;
	wire [3:0] freq_idx;
	wire [4:0] thr_idx;
	wire freq_hit;
	wire thr_hit;
	reg [31:0] rd_mux;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	assign accept = hsel && hready && htrans[1];
	assign freq_idx = dp_addr[5:2];
	assign thr_idx = dp_addr[6:2];
	assign freq_hit = (dp_addr[7:6] == 2'b01) && (freq_idx < PAIRS);
	assign thr_hit = dp_addr[7] && (thr_idx < PORTS);

	// out-of-range codes are pulled into the legal 8..4096 kHz span
	assign wr_code = (hwdata[9:0] == 10'h000) ? `TOSQ_FREQ_MIN :
		(hwdata[31:10] != 22'h00_0000 || hwdata[9:0] > `TOSQ_FREQ_MAX) ? `TOSQ_FREQ_MAX :
		hwdata[9:0]; // R03

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always @* begin
		rd_mux = 32'h0000_0000;
		if (freq_hit) begin
			rd_mux[9:0] = freq_flat[freq_idx*10 +: 10];
		end else if (thr_hit) begin
			rd_mux[QW-1:0] = thr_flat[thr_idx*QW +: QW];
		end else begin
			case (dp_addr)
				`TOSQ_OFS_CTRL: begin
					rd_mux[`TOSQ_CTRL_REDUNDANT] = redundant_en;
				end
				`TOSQ_OFS_PORT_OFF: begin
					rd_mux[PORTS-1:0] = port_off;
				end
				`TOSQ_OFS_SYS_PQL: begin
					rd_mux[QW-1:0] = sys_pql;
				end
				`TOSQ_OFS_SQ_STATE: begin
					rd_mux[PORTS-1:0] = report;
				end
				`TOSQ_OFS_ALARM: begin
					rd_mux[PORTS-1:0] = alarm_mask;
					rd_mux[`TOSQ_ALARM_EVENT] = alarm_event;
					rd_mux[`TOSQ_ALARM_ID_LSB +: 6] = `TOSQ_ALARM_ID;
				end
				`TOSQ_OFS_STATUS: begin
					rd_mux[`TOSQ_STATUS_BLANK] = blank;
					rd_mux[`TOSQ_STATUS_WAIT] = (rl_state == RL_WAIT);
				end
				default: begin
					rd_mux = 32'h0000_0000;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// ahb-lite slave
	// ----------------------------------------------------------------
	// reads take one wait state so a write just ahead is always seen
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			dp_addr <= 8'h00;
			hreadyout <= 1'b1;
			hrdata <= 32'h0000_0000;
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
			if (rd_pend) begin
				hrdata <= rd_mux;
				hreadyout <= 1'b1;
				rd_pend <= 1'b0;
			end else if (accept) begin
				dp_addr <= {haddr[7:2], 2'b00};
				wr_pend <= hwrite;
				rd_pend <= ~hwrite;
				hreadyout <= hwrite;
			end else begin
				wr_pend <= 1'b0;
			end
			if (rd_pend || !accept) begin
				wr_pend <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// configuration writes
	// ----------------------------------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			redundant_en <= `TOSQ_CTRL_RST;
			port_off <= `TOSQ_PORT_OFF_RST;
			sys_pql <= `TOSQ_PQL_RST;
			freq_flat <= {PAIRS{`TOSQ_FREQ_RST}};
			thr_flat <= {PORTS{`TOSQ_THR_RST}};
			notify_freq_load <= 1'b0;
			notify_freq_index <= 4'h0;
			notify_freq_code <= 10'h000;
		end else begin
			notify_freq_load <= 1'b0;
			if (wr_pend) begin
				if (freq_hit) begin
					// only pairs hold a setting; port n+10 shares it
					freq_flat[freq_idx*10 +: 10] <= wr_code; // R04
					notify_freq_load <= redundant_en;
					notify_freq_index <= freq_idx;
					notify_freq_code <= wr_code;
				end else if (thr_hit) begin
					thr_flat[thr_idx*QW +: QW] <= hwdata[QW-1:0];
				end else begin
					case (dp_addr)
						`TOSQ_OFS_CTRL: begin
							redundant_en <= hwdata[`TOSQ_CTRL_REDUNDANT];
						end
						`TOSQ_OFS_PORT_OFF: begin
							port_off <= hwdata[PORTS-1:0]; // R02
						end
						`TOSQ_OFS_SYS_PQL: begin
							sys_pql <= hwdata[QW-1:0];
						end
						default: begin
							sys_pql <= sys_pql;
						end
					endcase
				end
			end
			// the partner's retune outranks a local write in the same cycle
			if (redundant_en && partner_freq_load && partner_freq_index < PAIRS) begin
				freq_flat[partner_freq_index*10 +: 10] <= partner_freq_code; // R05
			end
		end
	end

	// ----------------------------------------------------------------
	// redundant-pair relock
	// ----------------------------------------------------------------
	// a partner that never marks its phase would blank the card for
	// good, so the wait gives up after a timeout and runs free
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rl_state <= RL_RUN;
			settle_cnt <= 8'h00;
			wait_cnt <= 32'h0000_0000;
			align_pulse <= 1'b0;
		end else begin
			align_pulse <= 1'b0;
			case (rl_state)
				RL_RUN: begin
					if (redundant_en && partner_freq_load) begin
						rl_state <= RL_WAIT; // R05
						wait_cnt <= 32'h0000_0000;
					end
				end
				RL_WAIT: begin
					if (partner_align) begin
						align_pulse <= 1'b1; // R05
						rl_state <= RL_SETTLE;
						settle_cnt <= 8'h00;
					end else if (wait_cnt >= TIMEOUT_CYC - 32'h0000_0001) begin
						rl_state <= RL_SETTLE;
						settle_cnt <= 8'h00;
					end else begin
						wait_cnt <= wait_cnt + 32'h0000_0001;
					end
				end
				RL_SETTLE: begin
					if (partner_freq_load && redundant_en) begin
						rl_state <= RL_WAIT;
						wait_cnt <= 32'h0000_0000;
					end else if (settle_cnt >= SETTLE_CYC - 8'h01) begin
						rl_state <= RL_RUN; // R05
					end else begin
						settle_cnt <= settle_cnt + 8'h01;
					end
				end
				default: begin
					rl_state <= RL_RUN;
				end
			endcase
		end
	end

	assign blank = (rl_state != RL_RUN);

	// ----------------------------------------------------------------
	// frequency generation, one divider per pair
	// ----------------------------------------------------------------
	genvar n;
	generate
		for (n = 0; n < PAIRS; n = n + 1) begin : g_pair
			tosq_divider #(
				.ACC_W(17)
			) u_div (
				.hclk(hclk),
				.hresetn(hresetn),
				.code(freq_flat[n*10 +: 10]),
				.align(align_pulse),
				.wave(wave[n])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// squelch compare
	// ----------------------------------------------------------------
	tosq_squelch #(
		.PORTS(PORTS),
		.QW(QW)
	) u_squelch (
		.pql(sys_pql),
		.thr_flat(thr_flat),
		.squelch(squelch),
		.report(report)
	);

	// a port runs unless switched off, squelched or blanked for relock
	assign live = ~port_off & ~squelch & {PORTS{~blank}}; // R02 R12

	// ----------------------------------------------------------------
	// squelch alarm
	// ----------------------------------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			squelch_q <= {PORTS{1'b0}};
			alarm_event <= 1'b0;
			alarm_mask <= {PORTS{1'b0}};
			squelch_alarm <= 1'b0;
			squelch_port_mask <= {PORTS{1'b0}};
		end else begin
			squelch_q <= squelch;
			if (squelch != squelch_q) begin
				// a crossing in the clear cycle still sets the flag
				alarm_event <= 1'b1; // R09
				alarm_mask <= report; // R10
			end else if (wr_pend && dp_addr == `TOSQ_OFS_ALARM && hwdata[`TOSQ_ALARM_EVENT]) begin
				alarm_event <= 1'b0;
			end
			squelch_alarm <= |squelch; // R09
			squelch_port_mask <= report; // R10 R11
		end
	end

	// ----------------------------------------------------------------
	// output pins
	// ----------------------------------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			balanced_tip_out <= {PAIRS{1'b0}};
			balanced_ring_out <= {PAIRS{1'b0}};
			single_out <= {PAIRS{1'b0}};
			port_relay_closed <= {PORTS{1'b0}};
		end else begin
			balanced_tip_out <= wave & live[PAIRS-1:0]; // R01
			balanced_ring_out <= ~wave & live[PAIRS-1:0]; // R01
			single_out <= wave & live[PORTS-1:PAIRS]; // R01 R04
			port_relay_closed <= live; // R02 R08 R12
		end
	end
endmodule // tosq_top

`default_nettype wire

// File: bench/tosq_partner.sv
`timescale 1ns/1ps
`default_nettype none
// far card of a redundant pair: announces a frequency change, then its phase marker unless the delay is zero
module tosq_partner (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic go,
	input wire logic [3:0] gidx,
	input wire logic [9:0] gcode,
	input wire logic [7:0] gdly,
	output logic partner_freq_load,
	output logic [3:0] partner_freq_index,
	output logic [9:0] partner_freq_code,
	output logic partner_align
);
	logic [7:0] cnt;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			partner_freq_load <= 1'b0;
			partner_freq_index <= 4'h0;
			partner_freq_code <= 10'h000;
			partner_align <= 1'b0;
			cnt <= 8'h00;
		end else begin
			partner_freq_load <= go;
			// index and code mean nothing outside the load, so scramble them there
			partner_freq_index <= go ? gidx : ~partner_freq_index;
			partner_freq_code <= go ? gcode : ~partner_freq_code;
			// zero delay never sends the marker: the card has to time out
			partner_align <= cnt == 8'h01;
			cnt <= go ? gdly : cnt - 8'(cnt != 8'h00);
		end
	end
endmodule // tosq_partner
`default_nettype wire

// File: bench/tosq_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tosq_chk #(
	parameter PAIRS = 10
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic notify_freq_load,
	input wire logic [3:0] notify_freq_index,
	input wire logic [9:0] notify_freq_code,
	input wire logic [PAIRS-1:0] balanced_tip_out,
	input wire logic [PAIRS-1:0] balanced_ring_out,
	input wire logic [PAIRS-1:0] single_out,
	input wire logic [2*PAIRS-1:0] port_relay_closed,
	input wire logic squelch_alarm,
	input wire logic [2*PAIRS-1:0] squelch_port_mask
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic wr_dp;
	logic [2*PAIRS-1:0] mask_rev;
	assign mask_rev = {<<{squelch_port_mask}};
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			wr_dp <= 1'b0;
		else if (hready)
			wr_dp <= hsel && htrans[1] && hwrite;
	sequence s_rd_req;
		hsel && hready && htrans[1] && !hwrite;
	endsequence
	sequence s_one_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	a_read_wait: assert property (s_rd_req |=> s_one_wait)
		else $error("read wait state wrong");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("error response seen");
	a_off_quiet: assert property (((balanced_tip_out | balanced_ring_out) & ~port_relay_closed[PAIRS-1:0]) == '0
		&& (single_out & ~port_relay_closed[2*PAIRS-1:PAIRS]) == '0)
		else $error("open port still drives");
	a_ring_inv: assert property (((balanced_ring_out ^ ~balanced_tip_out) & port_relay_closed[PAIRS-1:0]) == '0)
		else $error("ring is not inverse of tip");
	a_mask_open: assert property ((mask_rev & port_relay_closed) == '0)
		else $error("squelched port still connected");
	a_alarm_any: assert property (squelch_alarm == (squelch_port_mask != '0))
		else $error("alarm level disagrees with mask");
	a_mask_cause: assert property ($changed(squelch_port_mask) |-> $past(wr_dp, 2))
		else $error("mask moved without a write");
	a_notify_clamp: assert property (notify_freq_load |-> notify_freq_code inside {[10'h001:10'h200]})
		else $error("notified code out of range");
	a_notify_index: assert property (notify_freq_load |-> notify_freq_index < PAIRS)
		else $error("notified index out of range");
endmodule // tosq_chk
bind tosq_top tosq_chk #(.PAIRS(PAIRS)) u_chk (.*);
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hready, hreadyout, hresp, squelch_alarm, notify_freq_load, partner_freq_load, partner_align;
	logic [31:0] hrdata, q;
	logic [3:0] notify_freq_index, partner_freq_index, n_idx;
	logic [9:0] notify_freq_code, partner_freq_code, balanced_tip_out, balanced_ring_out, single_out, n_code;
	logic [19:0] port_relay_closed, squelch_port_mask, off, exp_rep, rr;
	logic go = 1'b0;
	logic [3:0] gidx = 4'h2;
	logic [9:0] gcode = 10'h000;
	logic [7:0] gdly = 8'h00;
	int n_fail = 0;
	int n_tests = 0;
	int seed = 65;
	int nseen = 0;
	int thr[20];
	int pql, t, c, e, ca, cb;
	logic [7:0] ra[11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h40, 8'h64, 8'h80, 8'hCC, 8'h3C, 8'h10};
	logic [31:0] rv[11] = '{0, 0, 0, 0, 0, 32'h0000_0100, 32'h0000_0100, 0, 0, 0, 32'h0E00_0000};
	assign hready = hreadyout;
	tosq_top #(.ALIGN_TIMEOUT(50)) DUT (.*);
	tosq_partner u_partner (.*);
	initial begin
		forever #4 hclk = ~hclk;
	end
	always @(posedge hclk)
		if (notify_freq_load === 1'b1) begin
			nseen <= nseen + 1;
			n_idx <= notify_freq_index;
			n_code <= notify_freq_code;
		end
	// ----
	// bus and compare helpers
	// ----
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		n_tests++;
		if (g !== x) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic chk_out();
		repeat (2) @(posedge hclk);
		exp_rep = 20'h0_0000;
		for (int i = 0; i < 20; i++)
			exp_rep[19-i] = thr[i] != 0 && pql > thr[i];
		rr = {<<{exp_rep}};
		rr = ~(rr | off);
		chk("mask", exp_rep, squelch_port_mask);
		chk("relay", rr, port_relay_closed);
		chk("alarm", |exp_rep, squelch_alarm);
	endtask
	// lo: earliest cycle at which the ports may come back
	task automatic relock(input logic [7:0] dly, input int lo);
		realtime t0;
		@(posedge hclk);
		go <= 1'b1;
		gcode <= 10'h040 + 10'(dly);
		gdly <= dly;
		t0 = $realtime;
		@(posedge hclk);
		go <= 1'b0;
		rd(8'h14);
		chk("wait", 1, q[1]);
		chk("blank_bit", 1, q[0]);
		chk("blank", 0, port_relay_closed);
		while (port_relay_closed !== 20'hF_FFFF && $realtime - t0 < 3200)
			@(posedge hclk);
		t = int'(($realtime - t0) / 8);
		chk("resume", 1, t >= lo && t <= lo + 15);
		rd(8'h48);
		chk("freq", 10'h040 + 10'(dly), q);
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ----
	// scenarios
	// ----
	initial begin
		#160000;
		n_fail++;
		stop_test();
	end
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		wr(8'h0C, 32'h000F_FFFF);
		wr(8'h3C, 32'hFFFF_FFFF);
		for (int i = 0; i < 11; i++) begin
			rd(ra[i]);
			chk("reset", rv[i], q);
		end
		wr(8'h44, 0);
		rd(8'h44);
		chk("fmin", 1, q);
		wr(8'h48, 32'h0000_0258);
		rd(8'h48);
		chk("fmax", 32'h0000_0200, q);
		c = 64 + ($random(seed) & 255);
		wr(8'h40, c);
		repeat (10) @(posedge hclk);
		ca = 0;
		cb = 0;
		// count rising edges of port 1 and its single-ended follower
		for (int i = 0; i < 4000; i++) begin
			rr[0] = balanced_tip_out[0];
			rr[1] = single_out[0];
			@(posedge hclk);
			ca += balanced_tip_out[0] & ~rr[0];
			cb += single_out[0] & ~rr[1];
		end
		e = c * 32 / 125;
		chk("tip_rate", 1, ca >= e - 1 && ca <= e + 1);
		chk("single_rate", 1, cb >= e - 1 && cb <= e + 1);
		for (int k = 0; k < 10; k++) begin
			pql = 0;
			wr(8'h08, 0);
			for (int i = 0; i < 20; i++) begin
				thr[i] = k == 0 ? (i < 5 ? 3 : 0) : $random(seed) & 15;
				wr(8'(8'h80 + 4 * i), thr[i]);
			end
			off = k == 0 ? 20'h0_0000 : 20'($random(seed)) & 20'h0_0F0F;
			wr(8'h04, off);
			wr(8'h10, 32'h0010_0000);
			pql = k == 0 ? 4 : k == 1 ? thr[0] : $random(seed) & 15;
			wr(8'h08, pql);
			chk_out();
			rd(8'h0C);
			chk("state", exp_rep, q);
			rd(8'h10);
			chk("alarm_reg", {|exp_rep, exp_rep}, q[20:0]);
		end
		off = 20'h0_0000;
		wr(8'h04, 0);
		wr(8'h08, 0);
		wr(8'h00, 1);
		relock(8'd30, 155);
		relock(8'd0, 170);
		wr(8'h54, 32'h0000_02BC);
		repeat (3) @(posedge hclk);
		chk("notify_count", 1, nseen);
		chk("notify_index", 5, n_idx);
		chk("notify_code", 10'h200, n_code);
		stop_test();
	end
endmodule // testbench
`default_nettype wire
